// *** ceimr_regs.sv ***
// clock enable, output disable and interrupt mask register group
`timescale 1ns/100ps
module ceimr_regs
  import ceimr_pkg::*;
#(
  parameter logic [CEIMR_CNT_W-1:0] STAGGER0_CYC = CEIMR_CNT_W'(CEIMR_STAGGER0_CYC),
  parameter logic [CEIMR_CNT_W-1:0] STAGGER1_CYC = CEIMR_CNT_W'(CEIMR_STAGGER1_CYC),
  parameter logic [CEIMR_CNT_W-1:0] STAGGER2_CYC = CEIMR_CNT_W'(CEIMR_STAGGER2_CYC),
  parameter logic [CEIMR_CNT_W-1:0] STAGGER3_CYC = CEIMR_CNT_W'(CEIMR_STAGGER3_CYC)
) (
  input wire logic clk_i,                          // 10 MHz system clock
  input wire logic rst_i,                          // async reset, active high
  input wire logic wr_en_i,                        // register write strobe
  input wire logic rd_en_i,                        // register read strobe
  input wire logic [7:0] addr_i,                   // register offset
  input wire logic [7:0] wdata_i,                  // write data
  output logic [7:0] rdata_o,                      // read data, one cycle after rd_en_i
  output logic rvalid_o,                           // read data valid pulse
  input wire ceimr_events_t events_i,              // monitor status levels, asynchronous
  input wire logic xo_loss_i,                      // reference oscillator loss, asynchronous
  input wire logic fuse_locked_i,                  // fuse-locked mode level, asynchronous
  input wire logic wake_start_i,                   // wake-up start pulse, same clock
  output logic [7:0] page_sel_o,                   // fuse page select, pointer bits with page 4 forced low
  output logic io_rail_sel_o,                      // 1 = input supply rail
  output ceimr_enables_t enables_o,                // active-high pad enables
  output logic [3:0] free_run_o,                   // one-hot free-run loop at wake-up
  output logic [3:0] loop_start_o,                 // loop enables, bit 0 = loop_a
  output logic [3:0] loop_output_disable_o,        // per-loop output disable
  output logic intr_o                              // interrupt, active high level
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  // page pointer and supply rail controls
  logic [7:0] fuse_page_pointer;
  logic [7:0] supply_rail_select;
  // pad enables, a zero bit leaves the pad enabled
  logic [7:0] input_fixed_output_enable;
  logic [7:0] flex_output_enable;
  // free-run choice, start delay and output disable causes
  logic [7:0] output_disable_control;
  // interrupt masks, a set bit silences its event
  logic [7:0] input_event_intr_mask;
  logic [7:0] loop_event_intr_mask;

  // plain strobe port standing in for the serial decoder, one access a strobe
  // zero reset
  // every field clears, so all pads come up enabled and nothing is masked
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fuse_page_pointer <= CEIMR_REG_RESET;
      supply_rail_select <= CEIMR_REG_RESET;
      input_fixed_output_enable <= CEIMR_REG_RESET;
      flex_output_enable <= CEIMR_REG_RESET;
      output_disable_control <= CEIMR_REG_RESET;
      input_event_intr_mask <= CEIMR_REG_RESET;
      loop_event_intr_mask <= CEIMR_REG_RESET;
    end else if (wr_en_i) begin
      case (addr_i)
        CEIMR_FUSE_PAGE_POINTER: fuse_page_pointer <= wdata_i;
        CEIMR_SUPPLY_RAIL_SELECT: supply_rail_select <= wdata_i;
        CEIMR_INPUT_FIXED_OUTPUT_ENABLE: input_fixed_output_enable <= wdata_i;
        CEIMR_FLEX_OUTPUT_ENABLE: flex_output_enable <= wdata_i;
        CEIMR_OUTPUT_DISABLE_CONTROL: output_disable_control <= wdata_i;
        CEIMR_INPUT_EVENT_INTR_MASK: input_event_intr_mask <= wdata_i;
        CEIMR_LOOP_EVENT_INTR_MASK: loop_event_intr_mask <= wdata_i;
        default: ; // writes elsewhere are ignored
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;

  // unmapped offsets read as zero
  always_comb begin
    case (addr_i)
      CEIMR_FUSE_PAGE_POINTER: next_rdata = fuse_page_pointer;
      CEIMR_SUPPLY_RAIL_SELECT: next_rdata = supply_rail_select;
      CEIMR_INPUT_FIXED_OUTPUT_ENABLE: next_rdata = input_fixed_output_enable;
      CEIMR_FLEX_OUTPUT_ENABLE: next_rdata = flex_output_enable;
      CEIMR_OUTPUT_DISABLE_CONTROL: next_rdata = output_disable_control;
      CEIMR_INPUT_EVENT_INTR_MASK: next_rdata = input_event_intr_mask;
      CEIMR_LOOP_EVENT_INTR_MASK: next_rdata = loop_event_intr_mask;
      default: next_rdata = 8'h00;
    endcase
  end

  // read data holds until the next read
  // a write in the same cycle lands after the read, which returns the old value
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_en_i;
      if (rd_en_i) begin
        rdata_o <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // monitors and the fuse strap come from other logic and pads
  // each bit is an independent level, so skew between bits only delays one event
  ceimr_events_t ev_meta;
  ceimr_events_t ev_sync;
  logic [1:0] lvl_meta;
  logic [1:0] lvl_sync;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ev_meta <= '0;
      ev_sync <= '0;
      lvl_meta <= 2'h0;
      lvl_sync <= 2'h0;
    end else begin
      ev_meta <= events_i;
      ev_sync <= ev_meta;
      lvl_meta <= {fuse_locked_i, xo_loss_i};
      lvl_sync <= lvl_meta;
    end
  end

  // named views of the synchronised levels
  logic xo_loss_s;
  logic fuse_locked_s;
  assign xo_loss_s = lvl_sync[0];
  assign fuse_locked_s = lvl_sync[1];

  // ----------------------------------------------------------------
  // static decodes
  // ----------------------------------------------------------------
  logic [7:0] next_page_sel;
  ceimr_enables_t next_enables;
  logic [3:0] next_free_run;

  // field decodes of the stored registers
  always_comb begin
    // page decode
    // bit 7 is page 1 down to bit 0 page D; page 4 never selects
    next_page_sel = fuse_page_pointer;
    next_page_sel[CEIMR_RESERVED_PAGE] = 1'b0;
    next_enables.input_en = ~input_fixed_output_enable[CEIMR_INPUT_EN_LSB +: 4];
    next_enables.bottom_en = ~input_fixed_output_enable[CEIMR_BOTTOM_EN_LSB +: 2];
    next_enables.top_en = ~input_fixed_output_enable[CEIMR_TOP_EN_LSB +: 2];
    next_enables.flex_en = ~flex_output_enable;
    // free-run choice
    // the select field is ignored unless the feature bit is set
    next_free_run = 4'h0;
    if (supply_rail_select[CEIMR_FREE_RUN_EN_BIT]) begin
      next_free_run[output_disable_control[CEIMR_FREE_RUN_SEL_LSB +: 2]] = 1'b1;
    end
  end

  // pad controls registered so outputs never glitch during writes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      page_sel_o <= 8'h00;
      io_rail_sel_o <= 1'b0;
      enables_o <= '1;
      free_run_o <= 4'h0;
    end else begin
      page_sel_o <= next_page_sel;
      io_rail_sel_o <= supply_rail_select[CEIMR_IO_RAIL_BIT];
      enables_o <= next_enables;
      free_run_o <= next_free_run;
    end
  end

  // ----------------------------------------------------------------
  // staggered loop start
  // ----------------------------------------------------------------
  ceimr_seq_t seq_state;
  logic [CEIMR_CNT_W-1:0] stagger_cnt;
  logic [CEIMR_CNT_W-1:0] stagger_limit;

  // delay latched at the start pulse so a later write cannot cut it short
  // counts are parameters so a test can shrink the 4 ms to 4 s delays
  always_comb begin
    case (output_disable_control[CEIMR_STAGGER_LSB +: 2])
      2'h0: stagger_limit = STAGGER0_CYC;
      2'h1: stagger_limit = STAGGER1_CYC;
      2'h2: stagger_limit = STAGGER2_CYC;
      default: stagger_limit = STAGGER3_CYC;
    endcase
  end

  // stagger sequence
  // loop_a first, the others after the delay; unlocked parts start all at once
  // a second start pulse is ignored; only reset arms the sequence again
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      seq_state <= CEIMR_SEQ_IDLE;
      stagger_cnt <= '0;
      loop_start_o <= 4'h0;
    end else begin
      case (seq_state)
        CEIMR_SEQ_IDLE: begin
          if (wake_start_i) begin
            // the strap is read once here, so a later change cannot split the loops
            if (fuse_locked_s) begin
              seq_state <= CEIMR_SEQ_LOOP_A;
              stagger_cnt <= stagger_limit - 1'b1;
              loop_start_o <= 4'h1;
            end else begin
              seq_state <= CEIMR_SEQ_ALL;
              loop_start_o <= 4'hF;
            end
          end
        end
        CEIMR_SEQ_LOOP_A: begin
          if (stagger_cnt == '0) begin
            seq_state <= CEIMR_SEQ_ALL;
            loop_start_o <= 4'hF;
          end else begin
            stagger_cnt <= stagger_cnt - 1'b1;
          end
        end
        CEIMR_SEQ_ALL: loop_start_o <= 4'hF; // held until reset
        default: seq_state <= CEIMR_SEQ_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // output disable and interrupt
  // ----------------------------------------------------------------
  logic [3:0] lol_mask;
  logic [3:0] freeze_mask;
  logic [3:0] next_od;
  logic next_intr;

  // loop mask fields run a..d from the top bit; flip them to index order
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lol_mask[i] = loop_event_intr_mask[CEIMR_LOL_MASK_LSB + 3 - i];
      freeze_mask[i] = loop_event_intr_mask[CEIMR_FREEZE_MASK_LSB + 3 - i];
    end
  end

  // causes of the per-loop output disable; oscillator loss overrides
  always_comb begin
    next_od = ev_sync.lol & {4{output_disable_control[CEIMR_OD_ON_LOL_BIT]}};
    if (output_disable_control[CEIMR_OD_ON_XO_BIT] && xo_loss_s) begin
      next_od = 4'hF;
    end
  end

  // a plain OR with no latch: software reads the status to find the cause
  always_comb begin
    next_intr =
      |(ev_sync.drift & ~input_event_intr_mask[CEIMR_DRIFT_MASK_LSB +: 4]) |
      |(ev_sync.loss & ~input_event_intr_mask[CEIMR_LOSS_MASK_LSB +: 4]) |
      |(ev_sync.lol & ~lol_mask) |
      |(ev_sync.freeze & ~freeze_mask);
  end

  // level interrupt: follows the events, nothing sticky to clear
  // registered so mask writes never glitch the pins
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      loop_output_disable_o <= 4'h0;
      intr_o <= 1'b0;
    end else begin
      loop_output_disable_o <= next_od;
      intr_o <= next_intr;
    end
  end

endmodule : ceimr_regs

// *** ceimr_pkg.sv ***
// package for the clock enable and interrupt mask register group
package ceimr_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CEIMR_FUSE_PAGE_POINTER = 8'h22;
  localparam logic [7:0] CEIMR_SUPPLY_RAIL_SELECT = 8'h23;
  localparam logic [7:0] CEIMR_INPUT_FIXED_OUTPUT_ENABLE = 8'h24;
  localparam logic [7:0] CEIMR_FLEX_OUTPUT_ENABLE = 8'h25;
  localparam logic [7:0] CEIMR_OUTPUT_DISABLE_CONTROL = 8'h26;
  localparam logic [7:0] CEIMR_INPUT_EVENT_INTR_MASK = 8'h27;
  localparam logic [7:0] CEIMR_LOOP_EVENT_INTR_MASK = 8'h28;

  // reset value shared by every register
  localparam logic [7:0] CEIMR_REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CEIMR_IO_RAIL_BIT = 7;      // supply_rail_select
  localparam int CEIMR_FREE_RUN_EN_BIT = 5;  // supply_rail_select
  localparam int CEIMR_INPUT_EN_LSB = 4;     // input_fixed_output_enable[7:4]
  localparam int CEIMR_BOTTOM_EN_LSB = 2;    // input_fixed_output_enable[3:2]
  localparam int CEIMR_TOP_EN_LSB = 0;       // input_fixed_output_enable[1:0]
  localparam int CEIMR_FREE_RUN_SEL_LSB = 6; // output_disable_control[7:6]
  localparam int CEIMR_STAGGER_LSB = 2;      // output_disable_control[3:2]
  localparam int CEIMR_OD_ON_LOL_BIT = 1;    // output_disable_control[1]
  localparam int CEIMR_OD_ON_XO_BIT = 0;     // output_disable_control[0]
  localparam int CEIMR_DRIFT_MASK_LSB = 4;   // input_event_intr_mask[7:4]
  localparam int CEIMR_LOSS_MASK_LSB = 0;    // input_event_intr_mask[3:0]
  localparam int CEIMR_LOL_MASK_LSB = 4;     // loop_event_intr_mask[7:4], bit 7 = loop_a
  localparam int CEIMR_FREEZE_MASK_LSB = 0;  // loop_event_intr_mask[3:0], bit 3 = loop_a
  localparam int CEIMR_RESERVED_PAGE = 4;    // pointer bit of the unused page 4

  // ----------------------------------------------------------------
  // staggered loop start delays
  // ----------------------------------------------------------------
  localparam longint CEIMR_CLK_HZ = 10_000_000;
  localparam longint CEIMR_STAGGER0_US = 4_000;
  localparam longint CEIMR_STAGGER1_US = 40_000;
  localparam longint CEIMR_STAGGER2_US = 400_000;
  localparam longint CEIMR_STAGGER3_US = 4_000_000;
  localparam longint CEIMR_STAGGER0_CYC = CEIMR_STAGGER0_US * CEIMR_CLK_HZ / 1_000_000;
  localparam longint CEIMR_STAGGER1_CYC = CEIMR_STAGGER1_US * CEIMR_CLK_HZ / 1_000_000;
  localparam longint CEIMR_STAGGER2_CYC = CEIMR_STAGGER2_US * CEIMR_CLK_HZ / 1_000_000;
  localparam longint CEIMR_STAGGER3_CYC = CEIMR_STAGGER3_US * CEIMR_CLK_HZ / 1_000_000;
  localparam int CEIMR_CNT_W = 26;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  // monitored events, index 0 = ref_input_0 or loop_a
  typedef struct packed {
    logic [3:0] drift;  // frequency drift per clock input
    logic [3:0] loss;   // clock loss per clock input
    logic [3:0] lol;    // loss of lock per loop
    logic [3:0] freeze; // holdover freeze per loop
  } ceimr_events_t;

  // active-high enables seen by the pads
  typedef struct packed {
    logic [3:0] input_en;
    logic [1:0] bottom_en;
    logic [1:0] top_en;
    logic [7:0] flex_en;
  } ceimr_enables_t;

  typedef enum logic [1:0] {
    CEIMR_SEQ_IDLE,
    CEIMR_SEQ_LOOP_A,
    CEIMR_SEQ_ALL
  } ceimr_seq_t;

endpackage : ceimr_pkg

// *** ceimr_regs_sva.sv ***
// assertion checker for the clock enable and interrupt mask register group
`timescale 1ns/100ps
module ceimr_regs_sva
  import ceimr_pkg::*;
(
  input wire logic clk_i,                       // system clock
  input wire logic rst_i,                       // async reset
  input wire logic wr_en_i,                     // write strobe
  input wire logic [7:0] addr_i,                // offset
  input wire logic [7:0] wdata_i,               // write data
  input wire ceimr_events_t events_i,           // monitor events
  input wire logic xo_loss_i,                   // oscillator loss
  input wire logic [7:0] page_sel_o,            // page select
  input wire ceimr_enables_t enables_o,         // pad enables
  input wire logic [3:0] free_run_o,            // free-run loop
  input wire logic [3:0] loop_output_disable_o, // loop disables
  input wire logic intr_o                       // interrupt
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // shadow registers
  // ----------------------------------------------------------------
  // indexed by the low nibble of the offset, 0x22..0x28
  logic [7:0] sh [2:8];
  logic want_intr;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sh <= '{default: 8'h00};
    end else if (wr_en_i && addr_i >= 8'h22 && addr_i <= 8'h28) begin
      sh[addr_i[3:0]] <= wdata_i;
    end
  end
  // lock and freeze masks put loop_a at the high bit, so flip them
  assign want_intr = |(events_i.drift & ~sh[7][7:4]) | |(events_i.loss & ~sh[7][3:0])
    | |(events_i.lol & ~{sh[8][4], sh[8][5], sh[8][6], sh[8][7]})
    | |(events_i.freeze & ~{sh[8][0], sh[8][1], sh[8][2], sh[8][3]});
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_PAGE_SEL: assert property ($stable(sh[2])[*2] |-> page_sel_o == (sh[2] & 8'hEF))
    else $error("page select differs from pointer");
  AST_PAGE4_UNUSED: assert property (page_sel_o[4] == 1'b0)
    else $error("unused page decoded");
  AST_IN_FIXED_EN: assert property ($stable(sh[4])[*2] |-> enables_o[15:8] == ~sh[4])
    else $error("input or fixed output enable wrong");
  AST_FLEX_EN: assert property ($stable(sh[5])[*2] |-> enables_o[7:0] == ~sh[5])
    else $error("flex output enable wrong");
  AST_FREE_RUN: assert property ($stable({sh[3][5], sh[6][7:6]})[*2] |->
    free_run_o == (sh[3][5] ? 4'h1 << sh[6][7:6] : 4'h0))
    else $error("free-run select wrong");
  AST_LOL_OD: assert property ((sh[6][1] && $stable(events_i.lol))[*4] |->
    (loop_output_disable_o & events_i.lol) == events_i.lol)
    else $error("lock loss did not disable loop output");
  AST_XO_OD: assert property ((sh[6][0] && xo_loss_i)[*4] |->
    loop_output_disable_o == 4'hF)
    else $error("oscillator loss did not disable outputs");
  AST_OD_IDLE: assert property ((sh[6][1:0] == 2'b00)[*4] |->
    loop_output_disable_o == 4'h0)
    else $error("output disable without cause");
  AST_INTR: assert property (($stable(events_i) && $stable(sh[7])
    && $stable(sh[8]))[*4] |-> intr_o == want_intr)
    else $error("interrupt differs from unmasked events");
  AST_RESET: assert property ($fell(rst_i) |->
    enables_o == 16'hFFFF && page_sel_o == 8'h00 && !intr_o)
    else $error("outputs not at reset values");
endmodule : ceimr_regs_sva

bind ceimr_regs ceimr_regs_sva ceimr_regs_sva_inst (.clk_i, .rst_i, .wr_en_i, .addr_i,
  .wdata_i, .events_i, .xo_loss_i, .page_sel_o, .enables_o, .free_run_o,
  .loop_output_disable_o, .intr_o);

// *** ceimr_host.sv ***
// host model driving the register port of the group
`timescale 1ns/100ps
module ceimr_host (
  input wire logic clk_i,         // system clock
  output logic wr_en_o,           // write strobe
  output logic rd_en_o,           // read strobe
  output logic [7:0] addr_o,      // offset
  output logic [7:0] wdata_o,     // write data
  input wire logic [7:0] rdata_i, // read data
  input wire logic rvalid_i       // read valid
);
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // one write; the idle cycle after it keeps each signal to one change per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_en_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_en_o <= 1'b0;
    addr_o <= ~a; // released lines flip so stale values never match
    wdata_o <= ~d;
    @(posedge clk_i);
  endtask : wr
  // one read; data and valid are taken once the answering edge has settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    rd_en_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_en_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
    v = rvalid_i;
    @(posedge clk_i);
  endtask : rd
endmodule : ceimr_host

// *** ceimr_regs_bench.sv ***
// self-checking bench for the clock enable and interrupt mask register group
`timescale 1ns/100ps
module ceimr_regs_bench;
  import ceimr_pkg::*;
  localparam int STG [4] = '{4, 6, 8, 10};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wire logic wr_en, rd_en, rvalid, intr, io_rail;
  wire logic [7:0] addr, wdata, rdata, page_sel;
  wire logic [3:0] free_run, loop_start, lod;
  wire ceimr_enables_t en;
  ceimr_events_t ev = '0;
  logic xo = 1'b0, locked = 1'b0, wake = 1'b0, v;
  logic [7:0] d, w, a8, m [2:8];
  int failures = 0, num_checks = 0, seed = 86924, cyc = 0, n;

  ceimr_regs #(.STAGGER0_CYC(26'(STG[0])), .STAGGER1_CYC(26'(STG[1])),
    .STAGGER2_CYC(26'(STG[2])), .STAGGER3_CYC(26'(STG[3]))) ceimr_regs_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wr_en_i(wr_en), .rd_en_i(rd_en), .addr_i(addr),
    .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid), .events_i(ev), .xo_loss_i(xo),
    .fuse_locked_i(locked), .wake_start_i(wake), .page_sel_o(page_sel),
    .io_rail_sel_o(io_rail), .enables_o(en), .free_run_o(free_run),
    .loop_start_o(loop_start), .loop_output_disable_o(lod), .intr_o(intr));
  ceimr_host ceimr_host_inst (.clk_i(clk_i), .wr_en_o(wr_en), .rd_en_o(rd_en),
    .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid));

  always #50 clk_i = ~clk_i;
  // hang guard, far above the fewer than a thousand cycles the run needs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (failures == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (m[i]) m[i] = 8'h00;
    @(posedge clk_i);
  endtask : do_reset
  // unmasked events, lock and freeze masks flipped
  function automatic logic exp_intr(ceimr_events_t e, logic [7:0] a, logic [7:0] b);
    return |(e.drift & ~a[7:4]) || |(e.loss & ~a[3:0])
      || |(e.lol & ~{b[4], b[5], b[6], b[7]}) || |(e.freeze & ~{b[0], b[1], b[2], b[3]});
  endfunction : exp_intr

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    for (int a = 8'h22; a <= 8'h29; a++) begin
      ceimr_host_inst.rd(8'(a), d, v);
      chk("reset read", 8'h00, d);
      chk("read valid", 1'b1, v);
    end
    chk("reset enables", 16'hFFFF, en);
    // reserved page alone decodes to nothing
    ceimr_host_inst.wr(8'h22, 8'h10);
    m[2] = 8'h10;
    #1;
    chk("page select", 8'h00, page_sel);
    for (int k = 0; k < 4; k++) begin
      ceimr_host_inst.wr(8'h23, 8'h20);
      ceimr_host_inst.wr(8'h26, 8'(k << 6));
      m[3] = 8'h20;
      m[6] = 8'(k << 6);
      @(posedge clk_i);
      #1;
      chk("free run", 4'h1 << k, free_run);
    end
    // random writes with readback and derived outputs
    for (int k = 0; k < 40; k++) begin
      a8 = 8'h22 + 8'($unsigned($random(seed)) % 8);
      w = (k < 2) ? {8{k[0]}} : 8'($random(seed));
      ceimr_host_inst.wr(a8, w);
      if (a8 != 8'h29) m[a8[3:0]] = w;
      ceimr_host_inst.rd(a8, d, v);
      chk("readback", (a8 == 8'h29) ? 8'h00 : w, d);
      chk("page select", m[2] & 8'hEF, page_sel);
      chk("rail select", m[3][7], io_rail);
      chk("pad enables", ~{m[4], m[5]}, en);
      chk("free run", m[3][5] ? 4'h1 << m[6][7:6] : 4'h0, free_run);
    end
    // events against random masks; first two runs all-clear then all-set
    for (int k = 0; k < 40; k++) begin
      m[6] = 8'($random(seed));
      m[7] = (k < 2) ? {8{k[0]}} : 8'($random(seed));
      m[8] = (k < 2) ? {8{k[0]}} : 8'($random(seed));
      ev <= (k < 2) ? 16'hFFFF : 16'($random(seed));
      xo <= (k > 1) && ($random(seed) % 3 == 0);
      ceimr_host_inst.wr(8'h26, m[6]);
      ceimr_host_inst.wr(8'h27, m[7]);
      ceimr_host_inst.wr(8'h28, m[8]);
      repeat (4) @(posedge clk_i);
      #1;
      v = exp_intr(ev, m[7], m[8]);
      chk("interrupt", v, intr);
      chk("loop disable", (m[6][1] ? ev.lol : 4'h0) | {4{m[6][0] & xo}}, lod);
      @(posedge clk_i);
    end
    // staggered start for each delay code, then unlocked start
    for (int k = 0; k < 5; k++) begin
      locked <= (k < 4);
      do_reset();
      ceimr_host_inst.wr(8'h26, 8'(k % 4) << 2);
      wake <= 1'b1;
      @(posedge clk_i);
      wake <= 1'b0;
      #1;
      chk("first loops", (k < 4) ? 4'h1 : 4'hF, loop_start);
      n = 0;
      while (loop_start !== 4'hF && n < 50) begin
        @(posedge clk_i);
        #1;
        n++;
      end
      chk("stagger delay", (k < 4) ? STG[k] : 0, n);
    end
    tally_and_finish();
  end
endmodule : ceimr_regs_bench
